//--- src/microstep_indexer_chop_ctrl.sv
// Microstep indexer, direct bridge mode and chopping control with an APB register slave.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Direct select bypasses indexer, pins drive bridges.
// - Direct input pairs decode to off, reverse, forward, brake.
// - Direct mode treats current as falling, so mixed and auto decay go fast first every cycle.
// - Direct mode keeps chopping with scaled full reference.
// - Threshold reached holds bridge off programmed time.
// - Comparator result against reference ends drive phase.
// - Direct reference code equals current scale setting.
// - Four-bit code selects full to 1/256 step.
// - Winding A follows sine, B follows cosine.
// - Power-up or chip clear returns to 45 degrees.
// - Advance pin edge or soft bit steps indexer.
// - Travel sense XOR reverse bit sets direction.
// - Positive current drives output 1 above output 2.
// - Resolution change lands on next valid state.
// - Indexer reference is sine times current scale.
module microstep_indexer_chop_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic step_advance_in,
  input wire logic travel_sense_in,
  input wire logic chip_clear_pin_b,
  input wire logic bridge_a_input_1,
  input wire logic bridge_a_input_2,
  input wire logic bridge_b_input_1,
  input wire logic bridge_b_input_2,
  input wire logic itrip_a,
  input wire logic itrip_b,
  output logic [1:0] sense_amp_gain_sel,
  output logic [7:0] dac_code_a,
  output logic [7:0] dac_code_b,
  output logic a_out1_hi,
  output logic a_out1_lo,
  output logic a_out2_hi,
  output logic a_out2_lo,
  output logic b_out1_hi,
  output logic b_out1_lo,
  output logic b_out2_hi,
  output logic b_out2_lo
);
  // Software-visible configuration.
  logic reverse_sense_bit_r;
  logic soft_advance_bit_r;
  logic [3:0] step_resolution_r;
  logic [7:0] current_scale_r;
  logic [7:0] chop_hold_time_r;
  logic direct_drive_select_r;
  logic [1:0] decay_mode_r;

  // Bus handshake.
  logic setup_phase;
  logic wr_en;
  logic mapped;
  logic [31:0] rd_mux;

  // Indexer state.
  logic step_prev_r;
  logic advance;
  logic step_fwd;
  logic [9:0] pos_r;
  logic [9:0] pos_b;
  logic [7:0] mag_a;
  logic [7:0] mag_b;
  logic [7:0] mag_a_prev_r;
  logic [7:0] mag_b_prev_r;
  logic falling_a_r;
  logic falling_b_r;
  logic [15:0] prod_a;
  logic [15:0] prod_b;
  logic [1:0] req_a;
  logic [1:0] req_b;
  logic hold_a;
  logic hold_b;

  // Coarse quarter-wave sine knots, 0 to 90 degrees in 17 points, 8-bit amplitude.
  function automatic logic [7:0] sine_knot(input logic [4:0] k);
    logic [7:0] v;
    v = 8'hff;
    case (k)
      5'd0: v = 8'h00;
      5'd1: v = 8'h19;
      5'd2: v = 8'h32;
      5'd3: v = 8'h4a;
      5'd4: v = 8'h62;
      5'd5: v = 8'h78;
      5'd6: v = 8'h8e;
      5'd7: v = 8'ha2;
      5'd8: v = 8'hb4;
      5'd9: v = 8'hc5;
      5'd10: v = 8'hd4;
      5'd11: v = 8'he1;
      5'd12: v = 8'hec;
      5'd13: v = 8'hf4;
      5'd14: v = 8'hfa;
      5'd15: v = 8'hfe;
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  // Magnitude of sine at an index of the 1024-state cycle.
  // Linear interpolation between knots keeps the table small at the cost of
  // roughly half an LSB of error between knot points.
  function automatic logic [7:0] sine_mag(input logic [9:0] ang);
    logic [8:0] m;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [11:0] prod;
    m = 9'h000;
    lo = 8'h00;
    hi = 8'h00;
    prod = 12'h000;
    if (ang[8]) begin
      m = 9'h100 - {1'b0, ang[7:0]};
    end else begin
      m = {1'b0, ang[7:0]};
    end
    lo = sine_knot(m[8:4]);
    hi = sine_knot(5'(m[8:4] + 5'h01));
    prod = 12'((hi - lo) * m[3:0]);
    return 8'(lo + prod[11:4]);
  endfunction

  // Next indexer state for the given resolution and direction.
  // Full step lives on odd multiples of 45 degrees, hence the offset.
  function automatic logic [9:0] next_pos(
    input logic [9:0] pos,
    input logic [3:0] res,
    input logic fwd
  );
    logic [3:0] res_sat;
    logic [9:0] off;
    logic [9:0] inc;
    logic [9:0] rel;
    logic [9:0] base;
    logic [9:0] nxt;
    res_sat = (res > stepper_pkg::RES_FINEST) ? stepper_pkg::RES_FINEST : res;
    off = (res_sat == 4'h0) ? stepper_pkg::FULL_STEP_OFFSET : 10'h000;
    inc = 10'h001 << (stepper_pkg::RES_FINEST - res_sat);
    rel = pos - off;
    base = rel & ~(inc - 10'h001);
    if (fwd) begin
      nxt = base + inc;
    end else if (rel == base) begin
      nxt = base - inc;
    end else begin
      nxt = base;
    end
    return nxt + off;
  endfunction

  // APB slave: one wait-free access phase after each setup cycle.
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign mapped = (paddr == stepper_pkg::OFS_CTRL) || (paddr == stepper_pkg::OFS_SCALE) ||
                  (paddr == stepper_pkg::OFS_HOLD) || (paddr == stepper_pkg::OFS_DECAY) ||
                  (paddr == stepper_pkg::OFS_STATUS);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      stepper_pkg::OFS_CTRL: begin
        rd_mux[stepper_pkg::CTRL_REV_BIT] = reverse_sense_bit_r;
        rd_mux[stepper_pkg::CTRL_GAIN_LSB +: 2] = sense_amp_gain_sel;
        rd_mux[stepper_pkg::CTRL_RES_LSB +: 4] = step_resolution_r;
      end
      stepper_pkg::OFS_SCALE: begin
        rd_mux[7:0] = current_scale_r;
      end
      stepper_pkg::OFS_HOLD: begin
        rd_mux[7:0] = chop_hold_time_r;
        rd_mux[stepper_pkg::HOLD_DIRECT_BIT] = direct_drive_select_r;
      end
      stepper_pkg::OFS_DECAY: begin
        rd_mux[1:0] = decay_mode_r;
      end
      stepper_pkg::OFS_STATUS: begin
        rd_mux[9:0] = pos_r;
        rd_mux[stepper_pkg::STAT_A_HOLD_BIT] = hold_a;
        rd_mux[stepper_pkg::STAT_B_HOLD_BIT] = hold_b;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !mapped;
      if (setup_phase) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reverse_sense_bit_r <= 1'b0;
      sense_amp_gain_sel <= stepper_pkg::GAIN_RESET;
      step_resolution_r <= stepper_pkg::RES_RESET;
      current_scale_r <= stepper_pkg::SCALE_RESET;
      chop_hold_time_r <= stepper_pkg::HOLD_RESET;
      direct_drive_select_r <= 1'b0;
      decay_mode_r <= stepper_pkg::DECAY_RESET;
    end else if (wr_en) begin
      if (paddr == stepper_pkg::OFS_CTRL) begin
        reverse_sense_bit_r <= pwdata[stepper_pkg::CTRL_REV_BIT];
        sense_amp_gain_sel <= pwdata[stepper_pkg::CTRL_GAIN_LSB +: 2];
        step_resolution_r <= pwdata[stepper_pkg::CTRL_RES_LSB +: 4];
      end
      if (paddr == stepper_pkg::OFS_SCALE) begin
        current_scale_r <= pwdata[7:0];
      end
      if (paddr == stepper_pkg::OFS_HOLD) begin
        chop_hold_time_r <= pwdata[7:0];
        direct_drive_select_r <= pwdata[stepper_pkg::HOLD_DIRECT_BIT];
      end
      if (paddr == stepper_pkg::OFS_DECAY) begin
        decay_mode_r <= pwdata[1:0];
      end
    end
  end

  // The soft advance lives for exactly one cycle so one write gives one step.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      soft_advance_bit_r <= 1'b0;
    end else begin
      soft_advance_bit_r <= wr_en && (paddr == stepper_pkg::OFS_CTRL) &&
                            pwdata[stepper_pkg::CTRL_ADV_BIT];
    end
  end

  // Indexer stepping.
  assign advance = (step_advance_in && !step_prev_r) || soft_advance_bit_r;
  assign step_fwd = travel_sense_in ^ reverse_sense_bit_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      step_prev_r <= 1'b0;
    end else begin
      step_prev_r <= step_advance_in;
    end
  end

  // Stepping is ignored in direct mode since the indexer is bypassed.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pos_r <= stepper_pkg::HOME_POS;
    end else if (!chip_clear_pin_b) begin
      pos_r <= stepper_pkg::HOME_POS;
    end else if (advance && !direct_drive_select_r) begin
      pos_r <= next_pos(pos_r, step_resolution_r, step_fwd);
    end
  end

  // Winding B runs a quarter cycle ahead, giving the cosine.
  assign pos_b = pos_r + stepper_pkg::QUARTER_CYCLE;
  assign mag_a = sine_mag(pos_r);
  assign mag_b = sine_mag(pos_b);
  assign prod_a = mag_a * current_scale_r;
  assign prod_b = mag_b * current_scale_r;

  // Current trend for mixed decay: latched whenever a magnitude moves.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mag_a_prev_r <= 8'h00;
      mag_b_prev_r <= 8'h00;
      falling_a_r <= 1'b0;
      falling_b_r <= 1'b0;
    end else begin
      mag_a_prev_r <= mag_a;
      mag_b_prev_r <= mag_b;
      if (mag_a != mag_a_prev_r) begin
        falling_a_r <= mag_a < mag_a_prev_r;
      end
      if (mag_b != mag_b_prev_r) begin
        falling_b_r <= mag_b < mag_b_prev_r;
      end
    end
  end

  // Reference codes for the sine-weighted DAC.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dac_code_a <= 8'h00;
      dac_code_b <= 8'h00;
    end else if (direct_drive_select_r) begin
      dac_code_a <= current_scale_r;
      dac_code_b <= current_scale_r;
    end else begin
      dac_code_a <= prod_a[15:8];
      dac_code_b <= prod_b[15:8];
    end
  end

  // Bridge requests: the pins in direct mode, the current sign otherwise.
  always_comb begin
    if (direct_drive_select_r) begin
      req_a = {bridge_a_input_1, bridge_a_input_2};
      req_b = {bridge_b_input_1, bridge_b_input_2};
    end else begin
      req_a = pos_r[9] ? 2'b01 : 2'b10;
      req_b = pos_b[9] ? 2'b01 : 2'b10;
    end
  end

  chop_phase u_chop_a (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .drive_req(req_a),
    .itrip(itrip_a),
    .hold_code(chop_hold_time_r),
    .decay_mode(decay_mode_r),
    .current_falling(direct_drive_select_r || falling_a_r),
    .out1_hi(a_out1_hi),
    .out1_lo(a_out1_lo),
    .out2_hi(a_out2_hi),
    .out2_lo(a_out2_lo),
    .in_hold(hold_a)
  );

  chop_phase u_chop_b (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .drive_req(req_b),
    .itrip(itrip_b),
    .hold_code(chop_hold_time_r),
    .decay_mode(decay_mode_r),
    .current_falling(direct_drive_select_r || falling_b_r),
    .out1_hi(b_out1_hi),
    .out1_lo(b_out1_lo),
    .out2_hi(b_out2_hi),
    .out2_lo(b_out2_lo),
    .in_hold(hold_b)
  );
endmodule
`default_nettype wire

//--- src/stepper_pkg.sv
// Shared constants and types for the microstep indexer and chopping core.
package stepper_pkg;
  // Register byte offsets on the APB slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SCALE = 8'h04;
  localparam logic [7:0] OFS_HOLD = 8'h08;
  localparam logic [7:0] OFS_DECAY = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Control register field positions.
  localparam int CTRL_REV_BIT = 0;
  localparam int CTRL_ADV_BIT = 1;
  localparam int CTRL_GAIN_LSB = 2;
  localparam int CTRL_RES_LSB = 4;
  // Hold-time register: direct drive select sits above the hold code.
  localparam int HOLD_DIRECT_BIT = 8;
  // Status register field positions.
  localparam int STAT_A_HOLD_BIT = 16;
  localparam int STAT_B_HOLD_BIT = 17;

  // Values after reset.
  localparam logic [3:0] RES_RESET = 4'h0;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [7:0] SCALE_RESET = 8'hff;
  localparam logic [7:0] HOLD_RESET = 8'h30;

  // Indexer geometry: 1024 states per electrical cycle at the finest resolution.
  localparam logic [9:0] HOME_POS = 10'h080;
  localparam logic [9:0] QUARTER_CYCLE = 10'h100;
  localparam logic [9:0] FULL_STEP_OFFSET = 10'h080;
  localparam logic [3:0] RES_FINEST = 4'h8;

  // Reference full scale in millivolts; the analog DAC realises it.
  localparam int VREF_FULL_SCALE_MV = 2750;

  // Off time: the hold code counts in units of 500 ns, code n gives (n+1) units.
  localparam int CHOP_HOLD_TIME_UNIT_NS = 500;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [13:0] CHOP_HOLD_TIME_UNIT_CYC =
    14'((CHOP_HOLD_TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    DECAY_SLOW = 2'h0,
    DECAY_FAST = 2'h1,
    DECAY_MIXED = 2'h2,
    DECAY_AUTO = 2'h3
  } decay_t;

  localparam decay_t DECAY_RESET = DECAY_SLOW;

  typedef enum logic [1:0] {
    CHOP_DRIVE = 2'b01,
    CHOP_HOLD = 2'b10
  } chop_state_t;
endpackage

//--- src/chop_phase.sv
// Fixed-off-time current chopper and output decode for one H-bridge.
`timescale 1ns/1ns
`default_nettype none
module chop_phase (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [1:0] drive_req,
  input wire logic itrip,
  input wire logic [7:0] hold_code,
  input wire logic [1:0] decay_mode,
  input wire logic current_falling,
  output logic out1_hi,
  output logic out1_lo,
  output logic out2_hi,
  output logic out2_lo,
  output logic in_hold
);
  stepper_pkg::chop_state_t state_r;
  logic [13:0] cnt_r;
  logic [13:0] half_r;
  logic [13:0] load;
  logic driving;
  logic fast_now;

  assign driving = (drive_req == 2'b10) || (drive_req == 2'b01);
  assign load = 14'(({6'h00, hold_code} + 14'h0001) * stepper_pkg::CHOP_HOLD_TIME_UNIT_CYC) - 14'h0001;

  // Mixed decay runs fast for the first half of the off time while current_falling is set, then slow; otherwise slow throughout.
  always_comb begin
    fast_now = 1'b0;
    if (decay_mode == stepper_pkg::DECAY_FAST) begin
      fast_now = 1'b1;
    end else if (decay_mode == stepper_pkg::DECAY_MIXED || decay_mode == stepper_pkg::DECAY_AUTO) begin
      fast_now = current_falling && (cnt_r > half_r);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= stepper_pkg::CHOP_DRIVE;
      cnt_r <= 14'h0000;
      half_r <= 14'h0000;
    end else begin
      unique case (state_r)
        stepper_pkg::CHOP_DRIVE: begin
          if (driving && itrip) begin
            state_r <= stepper_pkg::CHOP_HOLD;
            cnt_r <= load;
            half_r <= {1'b0, load[13:1]};
          end
        end
        stepper_pkg::CHOP_HOLD: begin
          if (cnt_r == 14'h0000) begin
            state_r <= stepper_pkg::CHOP_DRIVE;
          end else begin
            cnt_r <= cnt_r - 14'h0001;
          end
        end
      endcase
    end
  end

  // Outputs are registered; fast decay turns on the opposite FET pair.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out1_hi <= 1'b0;
      out1_lo <= 1'b0;
      out2_hi <= 1'b0;
      out2_lo <= 1'b0;
      in_hold <= 1'b0;
    end else begin
      in_hold <= (state_r == stepper_pkg::CHOP_HOLD);
      unique case (drive_req)
        2'b00: begin
          out1_hi <= 1'b0;
          out1_lo <= 1'b0;
          out2_hi <= 1'b0;
          out2_lo <= 1'b0;
        end
        2'b11: begin
          out1_hi <= 1'b0;
          out1_lo <= 1'b1;
          out2_hi <= 1'b0;
          out2_lo <= 1'b1;
        end
        2'b10: begin
          out1_hi <= (state_r == stepper_pkg::CHOP_DRIVE);
          out2_lo <= (state_r == stepper_pkg::CHOP_DRIVE) || !fast_now;
          out1_lo <= (state_r == stepper_pkg::CHOP_HOLD);
          out2_hi <= (state_r == stepper_pkg::CHOP_HOLD) && fast_now;
        end
        2'b01: begin
          out2_hi <= (state_r == stepper_pkg::CHOP_DRIVE);
          out1_lo <= (state_r == stepper_pkg::CHOP_DRIVE) || !fast_now;
          out2_lo <= (state_r == stepper_pkg::CHOP_HOLD);
          out1_hi <= (state_r == stepper_pkg::CHOP_HOLD) && fast_now;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- verification/microstep_chk.sv
// Assertion checker watching the ports of the indexer and chopping core.
`timescale 1ns/1ns
`default_nettype none
module microstep_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_clear_pin_b,
  input wire logic itrip_a,
  input wire logic [1:0] sense_amp_gain_sel,
  input wire logic [7:0] dac_code_a,
  input wire logic [7:0] dac_code_b,
  input wire logic a_out1_hi,
  input wire logic a_out1_lo,
  input wire logic a_out2_hi,
  input wire logic a_out2_lo
);
  logic wr_done;
  logic slow_pat;
  logic direct_r;
  logic [7:0] scale_r;
  logic [7:0] hold_r;
  logic [1:0] decay_r;
  logic [2:0] settle_r;
  logic [15:0] run_r;
  assign wr_done = psel && penable && pready && pwrite;
  assign slow_pat = a_out1_lo && a_out2_lo && !a_out1_hi && !a_out2_hi;
  // Shadow copies of the registers, since the checker cannot see inside.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      direct_r <= 1'b0;
      hold_r <= stepper_pkg::HOLD_RESET;
      scale_r <= stepper_pkg::SCALE_RESET;
      decay_r <= 2'h0;
    end else if (wr_done && paddr == stepper_pkg::OFS_HOLD) begin
      direct_r <= pwdata[stepper_pkg::HOLD_DIRECT_BIT];
      hold_r <= pwdata[7:0];
    end else if (wr_done && paddr == stepper_pkg::OFS_SCALE) begin
      scale_r <= pwdata[7:0];
    end else if (wr_done && paddr == stepper_pkg::OFS_DECAY) begin
      decay_r <= pwdata[1:0];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      settle_r <= 3'h0;
      run_r <= 16'h0000;
    end else begin
      settle_r <= wr_done ? 3'h0 : (settle_r == 3'h7 ? settle_r : settle_r + 3'h1);
      run_r <= slow_pat ? run_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_pready_after_setup;
    psel && !penable |=> pready && penable;
  endproperty
  a_pready_after_setup: assert property (p_pready_after_setup) else $error("no pready after setup");
  property p_pready_single;
    pready |=> !pready;
  endproperty
  a_pready_single: assert property (p_pready_single) else $error("pready longer than one cycle");
  property p_err_unmapped;
    pslverr |-> pready && (paddr > stepper_pkg::OFS_STATUS || paddr[1:0] != 2'h0);
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("pslverr on mapped address");
  property p_gain_write;
    wr_done && paddr == stepper_pkg::OFS_CTRL |=> sense_amp_gain_sel == $past(pwdata[3:2]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain select not taken");
  property p_reset_home;
    $rose(rst_b) |=> dac_code_a == 8'hb3 && dac_code_b == 8'hb3;
  endproperty
  a_reset_home: assert property (p_reset_home) else $error("home codes wrong");
  property p_clear_equal;
    !chip_clear_pin_b [*4] ##0 !direct_r |-> dac_code_a == dac_code_b;
  endproperty
  a_clear_equal: assert property (p_clear_equal) else $error("windings unequal at home");
  property p_direct_dac;
    direct_r && settle_r == 3'h7 |-> dac_code_a == scale_r && dac_code_b == scale_r;
  endproperty
  a_direct_dac: assert property (p_direct_dac) else $error("direct reference wrong");
  property p_chop_cut;
    a_out1_hi && a_out2_lo && itrip_a |-> ##2 !a_out1_hi;
  endproperty
  a_chop_cut: assert property (p_chop_cut) else $error("drive not cut by trip");
  property p_hold_len;
    a_out1_hi && $past(slow_pat) && decay_r == 2'h0 && $past(!direct_r || !a_out1_hi) |->
      run_r == 16'(({8'h00, hold_r} + 16'h0001) * stepper_pkg::CHOP_HOLD_TIME_UNIT_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("off time length wrong");
  c_ctrl_write: cover property (wr_done && paddr == stepper_pkg::OFS_CTRL);
  c_chop: cover property (a_out1_hi && itrip_a);
  c_clear: cover property (!chip_clear_pin_b [*4]);
endmodule
bind microstep_indexer_chop_ctrl microstep_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .chip_clear_pin_b(chip_clear_pin_b), .itrip_a(itrip_a),
  .sense_amp_gain_sel(sense_amp_gain_sel), .dac_code_a(dac_code_a), .dac_code_b(dac_code_b),
  .a_out1_hi(a_out1_hi), .a_out1_lo(a_out1_lo), .a_out2_hi(a_out2_hi), .a_out2_lo(a_out2_lo)
);
`default_nettype wire

//--- verification/motion_ctrl_model.sv
// Motion controller model driving the step, travel and direct bridge pins.
`timescale 1ns/1ns
`default_nettype none
module motion_ctrl_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic step_go,
  input wire logic dir_cmd,
  input wire logic [7:0] gap,
  input wire logic [3:0] pwm_code,
  output logic busy,
  output logic step_advance_in,
  output logic travel_sense_in,
  output logic bridge_a_input_1,
  output logic bridge_a_input_2,
  output logic bridge_b_input_1,
  output logic bridge_b_input_2
);
  logic [8:0] cnt_r;
  logic step_r;
  logic dir_r;
  logic [3:0] pwm_r;
  // Travel sense moves only between pulses, so it is settled around every rising edge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 9'h000;
      step_r <= 1'b0;
      dir_r <= 1'b0;
    end else if (step_go && cnt_r == 9'h000) begin
      cnt_r <= {gap, 1'b0};
      step_r <= 1'b1;
    end else if (cnt_r != 9'h000) begin
      cnt_r <= cnt_r - 9'h001;
      if (cnt_r == {1'b0, gap} + 9'h001) begin
        step_r <= 1'b0;
      end
    end else begin
      dir_r <= dir_cmd;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwm_r <= 4'h0;
    end else begin
      pwm_r <= pwm_code;
    end
  end
  assign busy = step_go || cnt_r != 9'h000;
  assign step_advance_in = rst_b && step_r;
  assign travel_sense_in = rst_b && dir_r;
  assign {bridge_a_input_1, bridge_a_input_2, bridge_b_input_1, bridge_b_input_2} =
    rst_b ? pwm_r : 4'h0;
endmodule
`default_nettype wire

//--- verification/microstep_indexer_chop_ctrl_test.sv
// Self-checking bench for the microstep indexer and chopping core.
`timescale 1ns/1ns
`default_nettype none
module microstep_indexer_chop_ctrl_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, busy;
  logic step_adv, trav, ai1, ai2, bi1, bi2;
  logic clr_b = 1'b1, itrip_a = 1'b0, itrip_b = 1'b0;
  logic step_go = 1'b0, dir_cmd = 1'b1;
  logic [7:0] gap = 8'hc8;
  logic [3:0] pwm = 4'ha;
  logic [1:0] gain;
  logic [7:0] dac_a, dac_b;
  wire [3:0] a_o, b_o;
  logic [9:0] exp_pos;
  logic [3:0] pat [4] = '{4'b0000, 4'b0110, 4'b1001, 4'b0101};
  int order [4] = '{3, 0, 1, 2};
  int fail_count = 0;
  int n_checks = 0;
  int k;
  always #5 clk_sys = ~clk_sys;
  motion_ctrl_model ctl (.clk_sys(clk_sys), .rst_b(rst_b), .step_go(step_go),
    .dir_cmd(dir_cmd), .gap(gap), .pwm_code(pwm), .busy(busy), .step_advance_in(step_adv),
    .travel_sense_in(trav), .bridge_a_input_1(ai1), .bridge_a_input_2(ai2),
    .bridge_b_input_1(bi1), .bridge_b_input_2(bi2));
  microstep_indexer_chop_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_advance_in(step_adv), .travel_sense_in(trav),
    .chip_clear_pin_b(clr_b), .bridge_a_input_1(ai1), .bridge_a_input_2(ai2),
    .bridge_b_input_1(bi1), .bridge_b_input_2(bi2), .itrip_a(itrip_a), .itrip_b(itrip_b),
    .sense_amp_gain_sel(gain), .dac_code_a(dac_a), .dac_code_b(dac_b),
    .a_out1_hi(a_o[3]), .a_out1_lo(a_o[2]), .a_out2_hi(a_o[1]), .a_out2_lo(a_o[0]),
    .b_out1_hi(b_o[3]), .b_out1_lo(b_o[2]), .b_out2_hi(b_o[1]), .b_out2_lo(b_o[0]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One transfer; entered just after a rising edge, leaves one idle cycle behind it.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic step();
    int n;
    step_go <= 1'b1;
    @(posedge clk_sys);
    step_go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (busy && n < 1000);
    if (n >= 1000) fail_count++;
  endtask
  initial begin
    #500000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rdc(stepper_pkg::OFS_CTRL, 32'h0);
    rdc(stepper_pkg::OFS_SCALE, 32'hff);
    rdc(stepper_pkg::OFS_HOLD, 32'h30);
    rdc(stepper_pkg::OFS_DECAY, 32'h0);
    rdc(stepper_pkg::OFS_STATUS, 32'h80);
    apb(1'b1, 8'h14, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    rdc(8'h14, 32'h0);
    exp_pos = 10'h080;
    for (k = 0; k < 4; k++) begin
      step();
      exp_pos = exp_pos + 10'h100;
      rdc(stepper_pkg::OFS_STATUS, {22'h0, exp_pos});
      if (k == 0) chk({a_o, b_o}, 32'h96);
    end
    for (k = 0; k <= 8; k++) begin
      apb(1'b1, stepper_pkg::OFS_CTRL, (k << 4) | ((k & 3) << 2));
      chk(gain, k & 3);
      step();
      exp_pos = exp_pos + (10'h100 >> k);
      rdc(stepper_pkg::OFS_STATUS, {22'h0, exp_pos});
    end
    apb(1'b1, stepper_pkg::OFS_CTRL, 32'h0);
    step();
    rdc(stepper_pkg::OFS_STATUS, 32'h280);
    exp_pos = 10'h280;
    for (k = 0; k < 4; k++) begin
      dir_cmd <= k[0];
      apb(1'b1, stepper_pkg::OFS_CTRL, {31'h0, k[1]});
      step();
      exp_pos = (k[0] ^ k[1]) ? exp_pos + 10'h100 : exp_pos - 10'h100;
      rdc(stepper_pkg::OFS_STATUS, {22'h0, exp_pos});
    end
    apb(1'b1, stepper_pkg::OFS_CTRL, 32'h3);
    repeat (3) @(posedge clk_sys);
    rdc(stepper_pkg::OFS_STATUS, {22'h0, exp_pos - 10'h100});
    rdc(stepper_pkg::OFS_CTRL, 32'h1);
    clr_b <= 1'b0;
    apb(1'b1, stepper_pkg::OFS_SCALE, 32'h80);
    step();
    rdc(stepper_pkg::OFS_STATUS, 32'h80);
    clr_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(dac_a, 32'h5a);
    apb(1'b1, stepper_pkg::OFS_SCALE, 32'h40);
    apb(1'b1, stepper_pkg::OFS_HOLD, 32'h100);
    step();
    rdc(stepper_pkg::OFS_STATUS, 32'h80);
    for (k = 0; k < 4; k++) begin
      pwm <= {order[k][1:0], order[k][1:0]};
      repeat (6) @(posedge clk_sys);
      chk({a_o, b_o}, {pat[order[k]], pat[order[k]]});
    end
    chk(dac_b, 32'h40);
    for (k = 0; k < 3; k += 2) begin
      apb(1'b1, stepper_pkg::OFS_DECAY, k);
      itrip_a <= 1'b1;
      @(posedge clk_sys);
      itrip_a <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(a_o, (k == 2) ? 32'h6 : 32'h5);
      rdc(stepper_pkg::OFS_STATUS, 32'h10080);
      repeat (60) @(posedge clk_sys);
      chk(a_o, 32'h9);
    end
    summarize();
  end
endmodule
`default_nettype wire
